/* File: bench/gpc_pin_model.sv */
// pin-side model: outside drivers, pull resistors, floating pins
// assumes the pad signals of the port controller and the bus clock hclk
module gpc_pin_model (
	input wire logic hclk,
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	input wire logic [7:0] pad_pull_up,
	input wire logic [7:0] pad_pull_down,
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	output logic [7:0] pad_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] flt = 8'h00;
	// ==========================================
	// pin level
	always @(posedge hclk) flt <= ~flt;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_oe[i]) pad_in[i] = pad_out[i];
			else if (ext_en[i]) pad_in[i] = ext_val[i];
			else if (pad_pull_up[i]) pad_in[i] = 1'b1;
			else if (pad_pull_down[i]) pad_in[i] = 1'b0;
			else pad_in[i] = flt[i];
		end
	end
endmodule // gpc_pin_model

/* File: bench/gpio_port_with_debounce_tb.sv */
// self-checking bench for the port controller over AHB-Lite
// assumes gpc_port with 8 pins, pin 7 a debug pin, a pin model on the pads
`define CMP(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module gpio_port_with_debounce_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic hreadyout, hresp, port_irq;
	logic [31:0] hrdata;
	logic [3:0] tick = '0;
	logic debug_mode = 1'b0;
	logic slp_m = 1'b0, slp_c = 1'b0;
	logic ck = 1'b0;
	logic [7:0] pad_in, pad_out, pad_oe, pu, pd, pin_rx, ext_val = '0, ext_en = '0;
	logic [3:0][7:0] p_out = '0, p_oe = '0;
	logic [39:0] q[$];
	logic [31:0] rs = 32'h123a8208;
	logic [7:0] oe_s = '0, out_s = '0, mod_s = 8'h80, r;
	logic [15:0] fs_s = '0, rp;
	int err_total = 0, checked = 0, tc = 0;
	gpc_port #(.GPIO_MASK(8'h7f), .DEBUG_MASK(8'h80)) u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .clk_src_tick(tick),
		.sleep_mode(slp_m), .sleep_clock_stop_bit(slp_c), .debug_mode(debug_mode),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pu),
		.pad_pull_down(pd), .periph_out(p_out), .periph_oe(p_oe), .periph_in(pin_rx),
		.port_irq(port_irq));
	gpc_pin_model u_pins (.hclk(hclk), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pull_up(pu), .pad_pull_down(pd), .ext_val(ext_val), .ext_en(ext_en),
		.pad_in(pad_in));
	// ==========================================
	// clock, source tick, random numbers
	initial forever #12.5 hclk = ~hclk;
	always @(posedge hclk) begin
		tc <= (tc + 1) % 4;
		tick <= {3'b000, tc == 0};
	end
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	function automatic logic [15:0] pads_exp();
		logic [7:0] o, d;
		for (int i = 0; i < 8; i++) begin
			o[i] = mod_s[i] ? p_oe[fs_s[2*i+:2]][i] : oe_s[i] & (i < 7);
			d[i] = mod_s[i] ? p_out[fs_s[2*i+:2]][i] : out_s[i];
		end
		return {o, d & o};
	endfunction
	// ==========================================
	// monitor: oldest note against what is seen
	always @(posedge hclk) begin
		if (ck && hreadyout) begin
			logic [39:0] e;
			e = q.pop_front();
			case (e[39:32])
				8'd0: begin
					`CMP("hrdata", e[31:0], hrdata)
					`CMP("hresp", 1'b0, hresp)
				end
				8'd1: `CMP("pads", e[15:0], {pad_oe, pad_out & pad_oe})
				8'd2: `CMP("pulls", e[15:0], {pu, pd})
				8'd4: `CMP("periph_in", e[7:0], pin_rx)
				default: `CMP("irq", e[0], port_irq)
			endcase
		end
	end
	// ==========================================
	// bus and check tasks
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic rdy();
		int n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			summarize();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		rdy();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		if (!w) begin
			q.push_back({8'd0, d});
			ck <= 1'b1;
		end
		rdy();
		ck <= 1'b0;
	endtask
	task automatic chk(input logic [7:0] k, input logic [31:0] v);
		repeat (2) @(posedge hclk);
		q.push_back({k, v});
		ck <= 1'b1;
		@(posedge hclk);
		ck <= 1'b0;
	endtask
	task automatic settle();
		repeat (40) @(posedge hclk);
	endtask
	// ==========================================
	// main sequence
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		p_out <= xs();
		p_oe <= xs();
		@(posedge hclk);
		for (int i = 0; i < 11; i++) bus(0, 8'(4 * i), i == 6 ? 32'h80 : 32'h0);
		chk(1, pads_exp());
		chk(2, 0);
		$display("reset test done");
		bus(1, gpc_pkg::GPC_OFF_IOEN, 32'hffff);
		bus(0, gpc_pkg::GPC_OFF_IOEN, 32'h7f7f);
		oe_s = 8'hff;
		for (int i = 0; i < 3; i++) begin
			out_s = 8'(xs()) & 8'h7f;
			bus(1, gpc_pkg::GPC_OFF_DAT, {16'h0, out_s, 8'h0});
			chk(1, pads_exp());
		end
		for (int i = 0; i < 3; i++) begin
			oe_s = 8'(xs());
			rp = 16'(xs());
			bus(1, gpc_pkg::GPC_OFF_IOEN, {24'h0, oe_s});
			bus(1, gpc_pkg::GPC_OFF_RCTL, {16'h0, rp});
			chk(2, {8'h7f & rp[7:0] & rp[15:8] & ~oe_s, 8'h7f & rp[7:0] & ~rp[15:8] & ~oe_s});
			chk(1, pads_exp());
		end
		$display("output and pull test done");
		oe_s = 8'h00;
		bus(1, gpc_pkg::GPC_OFF_IOEN, 32'h0);
		for (int f = 0; f < 4; f++) begin
			bus(1, gpc_pkg::GPC_OFF_MODSEL, 32'h80);
			mod_s = 8'h81;
			fs_s = 16'(f);
			bus(1, gpc_pkg::GPC_OFF_FNCSEL, {16'h0, fs_s});
			bus(1, gpc_pkg::GPC_OFF_MODSEL, {24'h0, mod_s});
			chk(1, pads_exp());
		end
		mod_s = 8'h00;
		bus(1, gpc_pkg::GPC_OFF_MODSEL, 32'h0);
		chk(1, pads_exp());
		$display("function test done");
		bus(1, gpc_pkg::GPC_OFF_IOEN, 32'hff00);
		bus(1, gpc_pkg::GPC_OFF_RCTL, 32'h0);
		ext_en <= 8'hff;
		for (int i = 0; i < 3; i++) begin
			r = 8'(xs());
			ext_val <= r;
			repeat (8) @(posedge hclk);
			bus(0, gpc_pkg::GPC_OFF_DAT, {16'h0, out_s, r & 8'h7f});
		end
		bus(1, gpc_pkg::GPC_OFF_IOEN, 32'h0f00);
		bus(0, gpc_pkg::GPC_OFF_DAT, {16'h0, out_s, r & 8'h0f});
		$display("input test done");
		ext_val <= 8'h00;
		repeat (8) @(posedge hclk);
		bus(1, gpc_pkg::GPC_OFF_INTCTL, 32'h0206);
		bus(1, gpc_pkg::GPC_OFF_INTF, 32'hff);
		ext_val <= 8'h06;
		repeat (8) @(posedge hclk);
		bus(0, gpc_pkg::GPC_OFF_INTF, 32'h04);
		chk(3, 1);
		bus(1, gpc_pkg::GPC_OFF_INTF, 32'h00);
		bus(0, gpc_pkg::GPC_OFF_INTF, 32'h04);
		bus(1, gpc_pkg::GPC_OFF_INTCTL, 32'h0200);
		chk(3, 0);
		bus(1, gpc_pkg::GPC_OFF_INTF, 32'h04);
		bus(0, gpc_pkg::GPC_OFF_INTF, 32'h00);
		ext_val <= 8'h00;
		repeat (8) @(posedge hclk);
		bus(0, gpc_pkg::GPC_OFF_INTF, 32'h02);
		$display("interrupt test done");
		bus(1, gpc_pkg::GPC_OFF_PCLK, 32'h1);
		bus(0, gpc_pkg::GPC_OFF_PCLK, 32'h0);
		bus(1, gpc_pkg::GPC_OFF_PROT, 32'h0096);
		bus(0, gpc_pkg::GPC_OFF_PROT, 32'h1);
		bus(1, gpc_pkg::GPC_OFF_PCLK, 32'h1);
		bus(0, gpc_pkg::GPC_OFF_PCLK, 32'h1);
		bus(1, gpc_pkg::GPC_OFF_PCLK, 32'h0);
		bus(1, gpc_pkg::GPC_OFF_PROT, 32'h0);
		bus(0, gpc_pkg::GPC_OFF_PROT, 32'h0);
		bus(1, gpc_pkg::GPC_OFF_CHATEN, 32'h08);
		bus(1, gpc_pkg::GPC_OFF_IOEN, 32'hff00);
		settle();
		bus(1, gpc_pkg::GPC_OFF_INTF, 32'hff);
		bus(1, gpc_pkg::GPC_OFF_INTCTL, 32'h0018);
		ext_val <= 8'h18;
		repeat (2) @(posedge hclk);
		ext_val <= 8'h00;
		settle();
		bus(0, gpc_pkg::GPC_OFF_INTF, 32'h10);
		ext_val <= 8'h18;
		settle();
		bus(0, gpc_pkg::GPC_OFF_DAT, {16'h0, out_s, 8'h18});
		chk(4, 32'h18);
		debug_mode <= 1'b1;
		settle();
		bus(0, gpc_pkg::GPC_OFF_DAT, {16'h0, out_s, 8'h10});
		chk(4, 32'h10);
		bus(1, gpc_pkg::GPC_OFF_PROT, 32'h0096);
		bus(1, gpc_pkg::GPC_OFF_PCLK, 32'h100);
		bus(1, gpc_pkg::GPC_OFF_PROT, 32'h0);
		settle();
		bus(0, gpc_pkg::GPC_OFF_DAT, {16'h0, out_s, 8'h18});
		$display("filter test done");
		debug_mode <= 1'b0;
		slp_m <= 1'b1;
		slp_c <= 1'b1;
		ext_val <= 8'h00;
		repeat (8) @(posedge hclk);
		bus(0, gpc_pkg::GPC_OFF_DAT, {16'h0, out_s, 8'h00});
		chk(4, 32'h00);
		slp_c <= 1'b0;
		bus(0, gpc_pkg::GPC_OFF_DAT, {16'h0, out_s, 8'h08});
		settle();
		bus(0, gpc_pkg::GPC_OFF_DAT, {16'h0, out_s, 8'h00});
		$display("sleep test done");
		summarize();
	end
endmodule // gpio_port_with_debounce_tb

/* File: common/gpc_pkg.sv */
// package for the port controller: register map, field positions, reset values
// assumes a 32-bit AHB-Lite slave with word-aligned registers
package gpc_pkg;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] GPC_OFF_DAT = 8'h00;
	localparam logic [7:0] GPC_OFF_IOEN = 8'h04;
	localparam logic [7:0] GPC_OFF_RCTL = 8'h08;
	localparam logic [7:0] GPC_OFF_INTF = 8'h0c;
	localparam logic [7:0] GPC_OFF_INTCTL = 8'h10;
	localparam logic [7:0] GPC_OFF_CHATEN = 8'h14;
	localparam logic [7:0] GPC_OFF_MODSEL = 8'h18;
	localparam logic [7:0] GPC_OFF_FNCSEL = 8'h1c;
	localparam logic [7:0] GPC_OFF_PCLK = 8'h20;
	localparam logic [7:0] GPC_OFF_PROT = 8'h24;
	localparam int GPC_AW = 8;

	// ==========================================================
	// field positions
	localparam int GPC_HI_LSB = 8;
	localparam int GPC_PCLK_SRC_LSB = 0;
	localparam int GPC_PCLK_DIV_LSB = 4;
	localparam int GPC_PCLK_DEBUG_RUN_BIT_BIT = 8;
	localparam int GPC_FSEL_W = 2;
	localparam int GPC_NFUNC = 4;
	localparam int GPC_DIV_W = 15;

	// ==========================================================
	// keys and reset values
	localparam logic [15:0] GPC_PROT_KEY = 16'h0096;
	localparam logic [15:0] GPC_PROT_RST = 16'h0000;

	typedef struct packed {
		logic debug_run_bit;
		logic [3:0] div;
		logic [1:0] src;
	} gpc_pclk_t;

	localparam gpc_pclk_t GPC_PCLK_RST = '0;

	typedef struct packed {
		logic valid;
		logic write;
		logic [GPC_AW-1:0] addr;
	} gpc_aphase_t;

	localparam gpc_aphase_t GPC_APHASE_RST = '0;

endpackage

/* File: design/gpc_port.sv */
// port controller: pin mux, pulls, chattering filter, edge flags, AHB-Lite registers
// assumes one clock hclk, same-domain clock-source ticks and mode inputs
//
// Contract
// [R01] non-debug pins reset off, floating, GPIO selected
// [R02] debug pins reset to debug function
// [R03] pull only when output off; select picks up/down
// [R04] non-GPIO pin GPIO bits read zero
// [R05] peripheral drives direction and data when selected
// [R06] enabled output drives output data bit
// [R07] input read shows level one clock earlier
// [R08] filter enable bit enables that pin only
// [R09] filter rejects pulses under sampling time
// [R10] one source select and divider for all
// [R11] protection key unlocks clock settings
// [R12] sleep clock stop bypasses filter
// [R13] debug without run stops clock, inputs inactive (here only on filter-enabled pins; others pass the synchronised level)
// [R14] debug run keeps filter running
// [R15] software disables interrupt before clock changes
// [R16] software waits four port clocks before enabling
// [R17] software peripheral hand-over sequence
// [R18] software GPIO output sequence
// [R19] software GPIO input sequence
// [R20] input disabled reads zero
// [R21] edge select one falling, zero rising
// [R22] flag set on edge, write one clears
// [R23] request only when flag and enable
// [R24] new level needs two equal samples
module gpc_port #(
	parameter int N_PINS = 8,
	parameter logic [N_PINS-1:0] GPIO_MASK = '1,
	parameter logic [N_PINS-1:0] FILTER_MASK = '1,
	parameter logic [N_PINS-1:0] IRQ_MASK = '1,
	parameter logic [N_PINS-1:0] DEBUG_MASK = '0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [3:0] clk_src_tick,
	input wire logic sleep_mode,
	input wire logic sleep_clock_stop_bit,
	input wire logic debug_mode,
	input wire logic [N_PINS-1:0] pad_in,
	output logic [N_PINS-1:0] pad_out,
	output logic [N_PINS-1:0] pad_oe,
	output logic [N_PINS-1:0] pad_pull_up,
	output logic [N_PINS-1:0] pad_pull_down,
	input wire logic [3:0][N_PINS-1:0] periph_out,
	input wire logic [3:0][N_PINS-1:0] periph_oe,
	output logic [N_PINS-1:0] periph_in,
	output logic port_irq
);

	if (N_PINS < 1 || N_PINS > 8) begin : g_chk
		$error("N_PINS must be 1..8");
	end

	// ==========================================================
	// registers
	logic [N_PINS-1:0] out_d, ien, oen, pdpu, ren, flag, edge_sel, ie, cha, modsel;
	logic [2*N_PINS-1:0] fsel;
	gpc_pkg::gpc_pclk_t pclk;
	logic [15:0] prot;
	logic [N_PINS-1:0] next_out_d, next_ien, next_oen, next_pdpu, next_ren, next_flag;
	logic [N_PINS-1:0] next_edge_sel, next_ie, next_cha, next_modsel;
	logic [2*N_PINS-1:0] next_fsel;
	gpc_pkg::gpc_pclk_t next_pclk;
	logic [15:0] next_prot;
	gpc_pkg::gpc_aphase_t ap, next_ap;
	logic [31:0] next_hrdata;
	logic [N_PINS-1:0] wd, wh, clr, ev, in_bit;
	logic unlocked;

	// ==========================================================
	// ahb-lite slave, zero wait states
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign wd = hwdata[N_PINS-1:0];
	assign wh = hwdata[gpc_pkg::GPC_HI_LSB +: N_PINS];
	assign unlocked = (prot == gpc_pkg::GPC_PROT_KEY); // [R11]

	always_comb begin
		next_ap.valid = hsel & hready & htrans[1];
		next_ap.write = hwrite;
		next_ap.addr = haddr[gpc_pkg::GPC_AW-1:0];
		next_out_d = out_d;
		next_ien = ien;
		next_oen = oen;
		next_pdpu = pdpu;
		next_ren = ren;
		next_edge_sel = edge_sel;
		next_ie = ie;
		next_cha = cha;
		next_modsel = modsel;
		next_fsel = fsel;
		next_pclk = pclk;
		next_prot = prot;
		clr = '0;
		if (ap.valid && ap.write) begin
			case (ap.addr)
				gpc_pkg::GPC_OFF_DAT: next_out_d = wh & GPIO_MASK; // [R04]
				gpc_pkg::GPC_OFF_IOEN: begin
					next_ien = wh & GPIO_MASK; // [R04]
					next_oen = wd & GPIO_MASK;
				end
				gpc_pkg::GPC_OFF_RCTL: begin
					next_pdpu = wh & GPIO_MASK;
					next_ren = wd & GPIO_MASK;
				end
				gpc_pkg::GPC_OFF_INTF: clr = wd; // [R22]
				gpc_pkg::GPC_OFF_INTCTL: begin
					next_edge_sel = wh & IRQ_MASK;
					next_ie = wd & IRQ_MASK;
				end
				gpc_pkg::GPC_OFF_CHATEN: next_cha = wd & FILTER_MASK; // [R08]
				gpc_pkg::GPC_OFF_MODSEL: next_modsel = wd;
				gpc_pkg::GPC_OFF_FNCSEL: next_fsel = hwdata[2*N_PINS-1:0];
				gpc_pkg::GPC_OFF_PCLK: begin
					if (unlocked) begin // [R11]
						next_pclk.src = hwdata[gpc_pkg::GPC_PCLK_SRC_LSB +: 2];
						next_pclk.div = hwdata[gpc_pkg::GPC_PCLK_DIV_LSB +: 4];
						next_pclk.debug_run_bit = hwdata[gpc_pkg::GPC_PCLK_DEBUG_RUN_BIT_BIT];
					end
				end
				gpc_pkg::GPC_OFF_PROT: next_prot = hwdata[15:0];
				default: ;
			endcase
		end
		next_flag = (flag & ~clr) | ev; // [R22]
	end

	// read data taken at the address edge, from next register values and the current input bits
	always_comb begin
		next_hrdata = '0;
		if (next_ap.valid && !hwrite) begin
			case (next_ap.addr)
				gpc_pkg::GPC_OFF_DAT: begin
					next_hrdata[gpc_pkg::GPC_HI_LSB +: N_PINS] = next_out_d;
					next_hrdata[N_PINS-1:0] = in_bit; // [R07]
				end
				gpc_pkg::GPC_OFF_IOEN: begin
					next_hrdata[gpc_pkg::GPC_HI_LSB +: N_PINS] = next_ien;
					next_hrdata[N_PINS-1:0] = next_oen;
				end
				gpc_pkg::GPC_OFF_RCTL: begin
					next_hrdata[gpc_pkg::GPC_HI_LSB +: N_PINS] = next_pdpu;
					next_hrdata[N_PINS-1:0] = next_ren;
				end
				gpc_pkg::GPC_OFF_INTF: next_hrdata[N_PINS-1:0] = next_flag;
				gpc_pkg::GPC_OFF_INTCTL: begin
					next_hrdata[gpc_pkg::GPC_HI_LSB +: N_PINS] = next_edge_sel;
					next_hrdata[N_PINS-1:0] = next_ie;
				end
				gpc_pkg::GPC_OFF_CHATEN: next_hrdata[N_PINS-1:0] = next_cha;
				gpc_pkg::GPC_OFF_MODSEL: next_hrdata[N_PINS-1:0] = next_modsel;
				gpc_pkg::GPC_OFF_FNCSEL: next_hrdata[2*N_PINS-1:0] = next_fsel;
				gpc_pkg::GPC_OFF_PCLK: begin
					next_hrdata[gpc_pkg::GPC_PCLK_SRC_LSB +: 2] = next_pclk.src;
					next_hrdata[gpc_pkg::GPC_PCLK_DIV_LSB +: 4] = next_pclk.div;
					next_hrdata[gpc_pkg::GPC_PCLK_DEBUG_RUN_BIT_BIT] = next_pclk.debug_run_bit;
				end
				gpc_pkg::GPC_OFF_PROT: next_hrdata[0] = (next_prot == gpc_pkg::GPC_PROT_KEY);
				default: next_hrdata = '0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap <= gpc_pkg::GPC_APHASE_RST;
			hrdata <= '0;
			out_d <= '0; // [R01]
			ien <= '0;
			oen <= '0;
			pdpu <= '0;
			ren <= '0;
			flag <= '0;
			edge_sel <= '0;
			ie <= '0;
			cha <= '0;
			modsel <= DEBUG_MASK; // [R02]
			fsel <= '0;
			pclk <= gpc_pkg::GPC_PCLK_RST;
			prot <= gpc_pkg::GPC_PROT_RST;
		end else begin
			ap <= next_ap;
			hrdata <= next_hrdata;
			out_d <= next_out_d;
			ien <= next_ien;
			oen <= next_oen;
			pdpu <= next_pdpu;
			ren <= next_ren;
			flag <= next_flag;
			edge_sel <= next_edge_sel;
			ie <= next_ie;
			cha <= next_cha;
			modsel <= next_modsel;
			fsel <= next_fsel;
			pclk <= next_pclk;
			prot <= next_prot;
		end
	end

	// ==========================================================
	// port clock enable: shared source and divider
	logic [gpc_pkg::GPC_DIV_W-1:0] div_cnt, next_div_cnt, div_lim;
	logic port_tick, clk_run, slp_stop, dbg_stop, src_en;

	assign slp_stop = sleep_mode & sleep_clock_stop_bit; // [R12]
	assign dbg_stop = debug_mode & ~pclk.debug_run_bit; // [R13] [R14]
	assign clk_run = ~slp_stop & ~dbg_stop;
	assign src_en = clk_src_tick[pclk.src]; // [R10]
	assign div_lim = gpc_pkg::GPC_DIV_W'((16'h0001 << pclk.div) - 16'h0001); // [R10]
	assign port_tick = clk_run & src_en & (div_cnt >= div_lim);

	always_comb begin
		next_div_cnt = div_cnt;
		if (clk_run && src_en) begin
			next_div_cnt = port_tick ? '0 : div_cnt + 1'b1;
		end
	end

	// ==========================================================
	// pin synchroniser and chattering filter
	logic [N_PINS-1:0] s1, s2, s3, lvl, samp, filt, prev_in;
	logic [N_PINS-1:0] next_lvl, next_samp, next_filt, use_filt, eff;

	always_comb begin
		next_lvl = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & lvl);
		next_samp = samp;
		next_filt = filt;
		if (port_tick) begin
			next_samp = lvl;
			next_filt = ((lvl ~^ samp) & lvl) | ((lvl ^ samp) & filt); // [R24] [R09]
		end
	end

	assign use_filt = cha & FILTER_MASK & {N_PINS{~slp_stop}}; // [R08] [R12]
	assign eff = (use_filt & (dbg_stop ? '0 : filt)) | (~use_filt & lvl); // [R13]
	assign in_bit = eff & ien & ~modsel & GPIO_MASK; // [R20]
	assign ev = IRQ_MASK & ~modsel & ((edge_sel & prev_in & ~in_bit)
		| (~edge_sel & ~prev_in & in_bit)); // [R21]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt <= '0;
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			lvl <= '0;
			samp <= '0;
			filt <= '0;
			prev_in <= '0;
		end else begin
			div_cnt <= next_div_cnt;
			s1 <= pad_in;
			s2 <= s1;
			s3 <= s2;
			lvl <= next_lvl;
			samp <= next_samp;
			filt <= next_filt;
			prev_in <= in_bit;
		end
	end

	// ==========================================================
	// pad and peripheral multiplexer
	logic [N_PINS-1:0] sel_out, sel_oe, next_pad_out, next_pad_oe, next_pu, next_pd;

	for (genvar i = 0; i < N_PINS; i++) begin : g_mux
		assign sel_out[i] = periph_out[fsel[2*i +: 2]][i];
		assign sel_oe[i] = periph_oe[fsel[2*i +: 2]][i];
	end

	always_comb begin
		next_pad_oe = (modsel & sel_oe) | (~modsel & oen); // [R05] [R06]
		next_pad_out = (modsel & sel_out) | (~modsel & oen & out_d); // [R06]
		next_pu = ~modsel & ~oen & ren & pdpu; // [R03]
		next_pd = ~modsel & ~oen & ren & ~pdpu; // [R03]
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pad_out <= '0;
			pad_oe <= '0;
			pad_pull_up <= '0;
			pad_pull_down <= '0;
			periph_in <= '0;
			port_irq <= 1'b0;
		end else begin
			pad_out <= next_pad_out;
			pad_oe <= next_pad_oe;
			pad_pull_up <= next_pu;
			pad_pull_down <= next_pd;
			periph_in <= eff;
			port_irq <= |(next_flag & next_ie); // [R23]
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic rst_seen;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_seen <= 1'b0;
		end else begin
			rst_seen <= 1'b1;
		end
	end

	sequence s_dat_read;
		next_ap.valid && !hwrite && next_ap.addr == gpc_pkg::GPC_OFF_DAT;
	endsequence

	property p_init_float;
		!rst_seen |-> ((pad_oe | pad_pull_up | pad_pull_down) & ~DEBUG_MASK) == '0;
	endproperty
	a_init_float: assert property (p_init_float) else $error("pin not floating after reset"); // [R01]

	property p_init_debug;
		!rst_seen |-> modsel == DEBUG_MASK && fsel == '0;
	endproperty
	a_init_debug: assert property (p_init_debug) else $error("debug pins not in debug use"); // [R02]

	property p_pull_off_when_driven;
		##1 ((pad_pull_up | pad_pull_down) & pad_oe & ~$past(modsel)) == '0;
	endproperty
	a_pull_off_when_driven: assert property (p_pull_off_when_driven) else $error("pull on driven pin"); // [R03]

	property p_gpio_drive;
		##1 ((pad_out ^ $past(out_d)) & $past(oen & ~modsel)) == '0;
	endproperty
	a_gpio_drive: assert property (p_gpio_drive) else $error("pin not driven from output data"); // [R06]

	property p_periph_drive;
		##1 ((pad_oe ^ $past(sel_oe)) & $past(modsel)) == '0;
	endproperty
	a_periph_drive: assert property (p_periph_drive) else $error("peripheral lost pin direction"); // [R05]

	property p_read_disabled_zero;
		s_dat_read ##0 (ien == '0) |=> hrdata[N_PINS-1:0] == '0;
	endproperty
	a_read_disabled_zero: assert property (p_read_disabled_zero) else $error("disabled input read 1"); // [R20]

	property p_clear_by_one;
		ap.valid && ap.write && ap.addr == gpc_pkg::GPC_OFF_INTF && (wd & ~ev) != '0
			|=> (flag & $past(wd & ~ev)) == '0;
	endproperty
	a_clear_by_one: assert property (p_clear_by_one) else $error("flag not cleared by one"); // [R22]

	property p_flag_hold;
		##1 ($past(flag & ~clr) & ~flag) == '0;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear"); // [R22]

	property p_filter_needs_two;
		port_tick |=> ((filt ^ $past(filt)) & $past(lvl ^ samp)) == '0;
	endproperty
	a_filter_needs_two: assert property (p_filter_needs_two) else $error("filter passed one sample"); // [R24]

	property p_debug_stop;
		dbg_stop |-> !port_tick && (in_bit & use_filt) == '0
			##1 (periph_in & $past(use_filt)) == '0;
	endproperty
	a_debug_stop: assert property (p_debug_stop) else $error("port clock ran in debug"); // [R13]

	property p_sleep_bypass;
		slp_stop |-> eff == lvl;
	endproperty
	a_sleep_bypass: assert property (p_sleep_bypass) else $error("filter not bypassed in sleep"); // [R12]

endmodule // gpc_port
